//--- core/dppc_consts.svh
`ifndef DPPC_CONSTS_SVH
`define DPPC_CONSTS_SVH
// ----------------------------------------------------------------
// register selects on the internal bus
// ----------------------------------------------------------------
`define DPPC_SEL_P3_DATA 3'h0
`define DPPC_SEL_P3_DIR 3'h1
`define DPPC_SEL_P3_FSEL 3'h2
`define DPPC_SEL_P4_DATA 3'h3
`define DPPC_SEL_PULLUP 3'h4
// ----------------------------------------------------------------
// reset values and read answers
// ----------------------------------------------------------------
`define DPPC_PULLUP_RST 8'h00
`define DPPC_P3_DIR_RST 8'hff
`define DPPC_P3_FSEL_RST 8'h00
`define DPPC_LATCH_RST 8'h00
`define DPPC_DIR_READ 8'h00
`define DPPC_UNMAPPED_READ 8'h00
// ----------------------------------------------------------------
// pull-up option field layout
// ----------------------------------------------------------------
`define DPPC_PULLUP_MASK 8'h7c
`define DPPC_PU_P3_BIT 3
`define DPPC_PU_P4_BIT 4
// ----------------------------------------------------------------
// expansion mode codes and alternate pin capability
// ----------------------------------------------------------------
`define DPPC_MM_INPUT 3'h0
`define DPPC_MM_OUTPUT 3'h1
`define DPPC_MM_BUS 3'h7
`define DPPC_P3_ALT_OUT_CAP 8'hfe
`endif

//--- core/dppc_pkg.sv
package dppc_pkg;
  // ----------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------
  // one port byte
  typedef logic [7:0] dppc_byte_t;
  // second port operating mode
  typedef enum logic [1:0] {
    DPPC_P4_INPUT,
    DPPC_P4_OUTPUT,
    DPPC_P4_BUS
  } dppc_p4_mode_e;
endpackage : dppc_pkg

//--- core/dppc_pin_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register view handed from the control logic to a pin group
// ----------------------------------------------------------------
interface dppc_pin_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] latch;   // output latch
  logic [WIDTH-1:0] dir_in;  // 1 = pin is an input
  logic [WIDTH-1:0] fsel;    // 1 = pin handed to alternate / bus use
  logic pull_opt;            // port pull-up option bit
  logic [WIDTH-1:0] rd_val;  // value a port read returns
  modport regs (output latch, output dir_in, output fsel, output pull_opt, input rd_val);
  modport pins (input latch, input dir_in, input fsel, input pull_opt, output rd_val);
endinterface : dppc_pin_if

//--- core/dppc_p3_bank.sv
`timescale 1ns/1ps
`include "dppc_consts.svh"
// ----------------------------------------------------------------
// first port: per-pin direction, alternate function, pull-up
// ----------------------------------------------------------------
module dppc_p3_bank #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register view
  dppc_pin_if.pins regs,
  // pins
  input wire logic [WIDTH-1:0] p3_pin_i,
  output logic [WIDTH-1:0] p3_pin_o,
  output logic [WIDTH-1:0] p3_pin_oe_o,
  output logic [WIDTH-1:0] p3_pullup_o,
  // peripherals
  input wire logic [WIDTH-1:0] alt_out_i,
  input wire logic [WIDTH-1:0] alt_oe_i,
  output logic [WIDTH-1:0] alt_in_o
);
  localparam logic [WIDTH-1:0] ALT_CAP = WIDTH'(`DPPC_P3_ALT_OUT_CAP);
  logic [WIDTH-1:0] pin_meta; // first synchroniser stage only
  logic [WIDTH-1:0] pin_sync; // pin level safe to read

  // two-stage synchroniser for the pin levels
  always_ff @(posedge ref_clk_i) begin
    pin_meta <= p3_pin_i;
    pin_sync <= pin_meta;
  end

  assign alt_in_o = pin_sync;

  genvar n;
  generate
    for (n = 0; n < WIDTH; n++) begin : g_pin
      // drivers: registered so the pad sees clean levels
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          p3_pin_o[n] <= 1'b0;
          p3_pin_oe_o[n] <= 1'b0;
          p3_pullup_o[n] <= 1'b0;
        end else if (regs.fsel[n]) begin
          p3_pin_o[n] <= alt_out_i[n];
          p3_pin_oe_o[n] <= alt_oe_i[n] & ALT_CAP[n];
          p3_pullup_o[n] <= regs.dir_in[n];
        end else begin
          p3_pin_o[n] <= regs.latch[n];
          p3_pin_oe_o[n] <= ~regs.dir_in[n];
          p3_pullup_o[n] <= regs.pull_opt & regs.dir_in[n];
        end
      end
      // read-back per pin
      always_comb begin
        if (regs.fsel[n]) begin
          regs.rd_val[n] = regs.dir_in[n] ? pin_sync[n] : (ALT_CAP[n] & alt_out_i[n]);
        end else begin
          regs.rd_val[n] = regs.dir_in[n] ? pin_sync[n] : regs.latch[n];
        end
      end
    end
  endgenerate
endmodule : dppc_p3_bank

//--- core/dppc_p4_unit.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// second port: whole-port direction or muxed address/data
// ----------------------------------------------------------------
module dppc_p4_unit #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register view; fsel all ones means bus mode
  dppc_pin_if.pins regs,
  // pins
  input wire logic [WIDTH-1:0] p4_pin_i,
  output logic [WIDTH-1:0] p4_pin_o,
  output logic [WIDTH-1:0] p4_pin_oe_o,
  output logic [WIDTH-1:0] p4_pullup_o,
  // external bus controller side
  input wire logic [WIDTH-1:0] ad_out_i,
  input wire logic ad_oe_i,
  output logic [WIDTH-1:0] ad_in_o
);
  logic [WIDTH-1:0] pin_meta; // first synchroniser stage only
  logic [WIDTH-1:0] pin_sync; // pin level safe to read

  // two-stage synchroniser for the pin levels
  always_ff @(posedge ref_clk_i) begin
    pin_meta <= p4_pin_i;
    pin_sync <= pin_meta;
  end

  assign ad_in_o = pin_sync;

  // registered pad drivers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      p4_pin_o <= '0;
      p4_pin_oe_o <= '0;
      p4_pullup_o <= '0;
    end else begin
      // bus mode hands pins to the bus
      p4_pin_o <= regs.fsel[0] ? ad_out_i : regs.latch;
      p4_pin_oe_o <= regs.fsel[0] ? {WIDTH{ad_oe_i}} : ~regs.dir_in;
      p4_pullup_o <= {WIDTH{regs.pull_opt}};
    end
  end

  // read-back: pins unless the port drives its latch
  always_comb begin
    regs.rd_val = (regs.fsel[0] | regs.dir_in[0]) ? pin_sync : regs.latch;
  end
endmodule : dppc_p4_unit

//--- core/dppc_top.sv
`timescale 1ns/1ps
`include "dppc_consts.svh"
// What this block does
// - one direction bit per first-port pin
// - direction written by whole bytes, unreadable
// - output pin drives latch, latch holds
// - input pin reads level, latch still writable
// - byte-wide read-modify-write on first port
// - function-select bit routes pin to peripheral
// - alternate output read: pin or peripheral
// - alternate input read pin when direction 1
// - pull-up when option set and input
// - alternate pin pulled up unless direction 0
// - second port mode from mode bits, pin
// - second port switches direction as whole
// - bus mode uses second port automatically
// - reset: second port input, high-impedance
// - second port pull-ups all eight together
// - second port input-mode RMW may corrupt latch
// - pull-up option bits 6..2, reset 00
// - reset: first port all inputs
// - each first-port pin has own alternate
module dppc_top #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // internal bus from the cpu core
  input wire logic [2:0] bus_sel_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic bus_bitop_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  // memory expansion control
  input wire logic [2:0] memory_expansion_mode_i,
  input wire logic external_access_pin_i,
  // first port pins
  input wire logic [WIDTH-1:0] p3_pin_i,
  output logic [WIDTH-1:0] p3_pin_o,
  output logic [WIDTH-1:0] p3_pin_oe_o,
  output logic [WIDTH-1:0] p3_pullup_o,
  // first port peripheral side
  input wire logic [WIDTH-1:0] alt_out_i,
  input wire logic [WIDTH-1:0] alt_oe_i,
  output logic [WIDTH-1:0] alt_in_o,
  // second port pins
  input wire logic [WIDTH-1:0] p4_pin_i,
  output logic [WIDTH-1:0] p4_pin_o,
  output logic [WIDTH-1:0] p4_pin_oe_o,
  output logic [WIDTH-1:0] p4_pullup_o,
  // external bus controller side
  input wire logic [WIDTH-1:0] muxed_address_data_low_i,
  input wire logic muxed_address_data_low_oe_i,
  output logic [WIDTH-1:0] muxed_address_data_low_o,
  // status towards the rest of the chip
  output logic [7:0] pullup_option_o,
  output logic p4_bus_mode_o
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the registers are bytes on the internal bus, so only eight pins fit
  generate
    if (WIDTH != 8) begin : g_bad_width
      $error("dppc_top: WIDTH must be 8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // first port output latch
  dppc_pkg::dppc_byte_t port3_latch;
  // first port direction, 1 = input
  dppc_pkg::dppc_byte_t port3_direction;
  // first port function select, 1 = alternate
  dppc_pkg::dppc_byte_t port3_function_select;
  // second port output latch
  dppc_pkg::dppc_byte_t port4_latch;
  // shared pull-up option register
  dppc_pkg::dppc_byte_t pullup_option;
  // second port operating mode
  dppc_pkg::dppc_p4_mode_e p4_mode;
  // mode decoded from the current inputs
  dppc_pkg::dppc_p4_mode_e next_p4_mode;
  // external-access pin synchroniser
  logic ea_meta;
  logic ea_sync;
  // per-register write strobes
  logic wr_p3_data;
  logic wr_p3_dir;
  logic wr_p3_fsel;
  logic wr_p4_data;
  logic wr_pullup;
  // carriers to the pin groups
  dppc_pin_if #(.WIDTH(WIDTH)) p3_if ();
  dppc_pin_if #(.WIDTH(WIDTH)) p4_if ();

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // one strobe per register; reads never change state here
  always_comb begin
    wr_p3_data = 1'b0;
    wr_p3_dir = 1'b0;
    wr_p3_fsel = 1'b0;
    wr_p4_data = 1'b0;
    wr_pullup = 1'b0;
    if (!bus_wr_i) begin
      // idle or read cycle: no strobe
      wr_p3_data = 1'b0;
    end else if (bus_sel_i == `DPPC_SEL_P3_DATA) begin
      wr_p3_data = 1'b1;
    end else if (bus_sel_i == `DPPC_SEL_P3_DIR) begin
      wr_p3_dir = ~bus_bitop_i;
    end else if (bus_sel_i == `DPPC_SEL_P3_FSEL) begin
      wr_p3_fsel = 1'b1;
    end else if (bus_sel_i == `DPPC_SEL_P4_DATA) begin
      // ignored while the bus owns the port
      wr_p4_data = (p4_mode != dppc_pkg::DPPC_P4_BUS);
    end else if (bus_sel_i == `DPPC_SEL_PULLUP) begin
      wr_pullup = 1'b1;
    end else begin
      // unmapped select: write dropped
      wr_pullup = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // first port registers
  // ----------------------------------------------------------------
  // output latch; the latch is data, its reset value is not promised
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port3_latch <= `DPPC_LATCH_RST;
    end else if (wr_p3_data) begin
      // whole byte replaced on every write
      port3_latch <= bus_wdata_i;
    end
  end

  // direction register; reset makes every pin an input
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port3_direction <= `DPPC_P3_DIR_RST;
    end else if (wr_p3_dir) begin
      port3_direction <= bus_wdata_i;
    end
  end

  // function select; every pin chooses on its own
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port3_function_select <= `DPPC_P3_FSEL_RST;
    end else if (wr_p3_fsel) begin
      // each pin its own select bit
      port3_function_select <= bus_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // shared pull-up option register
  // ----------------------------------------------------------------
  // unimplemented bits stay zero so they read back as zero
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pullup_option <= `DPPC_PULLUP_RST;
    end else if (wr_pullup) begin
      pullup_option <= bus_wdata_i & `DPPC_PULLUP_MASK;
    end
  end

  assign pullup_option_o = pullup_option;

  // ----------------------------------------------------------------
  // second port latch and mode
  // ----------------------------------------------------------------
  // latch keeps taking writes in input mode, shown once output
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port4_latch <= `DPPC_LATCH_RST;
    end else if (wr_p4_data) begin
      // whole byte replaced, pins read back in input and bus mode
      port4_latch <= bus_wdata_i;
    end
  end

  // external-access pin comes from outside the clock domain
  always_ff @(posedge ref_clk_i) begin
    ea_meta <= external_access_pin_i;
    ea_sync <= ea_meta;
  end

  // mode decode; undocumented codes keep the port a safe input
  always_comb begin
    if (!ea_sync) begin
      next_p4_mode = dppc_pkg::DPPC_P4_BUS;
    end else begin
      case (memory_expansion_mode_i)
        `DPPC_MM_INPUT: next_p4_mode = dppc_pkg::DPPC_P4_INPUT;
        `DPPC_MM_OUTPUT: next_p4_mode = dppc_pkg::DPPC_P4_OUTPUT;
        `DPPC_MM_BUS: next_p4_mode = dppc_pkg::DPPC_P4_BUS;
        default: next_p4_mode = dppc_pkg::DPPC_P4_INPUT;
      endcase
    end
  end

  // mode register; reset wins over the decode
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      p4_mode <= dppc_pkg::DPPC_P4_INPUT;
    end else begin
      p4_mode <= next_p4_mode;
    end
  end

  assign p4_bus_mode_o = (p4_mode == dppc_pkg::DPPC_P4_BUS);

  // ----------------------------------------------------------------
  // carrier wiring
  // ----------------------------------------------------------------
  // first port view
  assign p3_if.latch = port3_latch;
  assign p3_if.dir_in = port3_direction;
  assign p3_if.fsel = port3_function_select;
  assign p3_if.pull_opt = pullup_option[`DPPC_PU_P3_BIT];

  // second port view; direction and bus flag fan out to all pins
  // one direction for the whole port
  assign p4_if.dir_in = {WIDTH{p4_mode == dppc_pkg::DPPC_P4_INPUT}};
  assign p4_if.fsel = {WIDTH{p4_mode == dppc_pkg::DPPC_P4_BUS}};
  assign p4_if.latch = port4_latch;
  assign p4_if.pull_opt = pullup_option[`DPPC_PU_P4_BIT];

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  // combinational answer within the access; no read side effects
  always_comb begin
    bus_rdata_o = `DPPC_UNMAPPED_READ;
    if (!bus_rd_i) begin
      // idle: quiet bus
      bus_rdata_o = `DPPC_UNMAPPED_READ;
    end else if (bus_sel_i == `DPPC_SEL_P3_DATA) begin
      bus_rdata_o = p3_if.rd_val;
    end else if (bus_sel_i == `DPPC_SEL_P3_DIR) begin
      bus_rdata_o = `DPPC_DIR_READ;
    end else if (bus_sel_i == `DPPC_SEL_P3_FSEL) begin
      bus_rdata_o = port3_function_select;
    end else if (bus_sel_i == `DPPC_SEL_P4_DATA) begin
      bus_rdata_o = p4_if.rd_val;
    end else if (bus_sel_i == `DPPC_SEL_PULLUP) begin
      bus_rdata_o = pullup_option;
    end else begin
      bus_rdata_o = `DPPC_UNMAPPED_READ;
    end
  end

  // ----------------------------------------------------------------
  // pin groups
  // ----------------------------------------------------------------
  // first port: per-pin drivers, pull-ups and read-back
  dppc_p3_bank #(
    .WIDTH(WIDTH)
  ) u_p3_bank (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .regs(p3_if.pins),
    .p3_pin_i(p3_pin_i),
    .p3_pin_o(p3_pin_o),
    .p3_pin_oe_o(p3_pin_oe_o),
    .p3_pullup_o(p3_pullup_o),
    .alt_out_i(alt_out_i),
    .alt_oe_i(alt_oe_i),
    .alt_in_o(alt_in_o)
  );

  // second port: whole-port drivers and bus multiplexing
  dppc_p4_unit #(
    .WIDTH(WIDTH)
  ) u_p4_unit (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .regs(p4_if.pins),
    .p4_pin_i(p4_pin_i),
    .p4_pin_o(p4_pin_o),
    .p4_pin_oe_o(p4_pin_oe_o),
    .p4_pullup_o(p4_pullup_o),
    .ad_out_i(muxed_address_data_low_i),
    .ad_oe_i(muxed_address_data_low_oe_i),
    .ad_in_o(muxed_address_data_low_o)
  );
endmodule : dppc_top

//--- verif/dppc_pin_env.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// board side of one pin group: resolves each wire level
// ----------------------------------------------------------------
module dppc_pin_env (
  // clock
  input wire logic clk_i,
  // device side
  input wire logic [7:0] oe_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] pullup_i,
  // outside driver
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_i,
  // resolved wire level
  output logic [7:0] level_o
);
  logic [7:0] float_q = 8'h00; // level of undriven lines
  // an undriven line without pull-up flips each cycle, so a stale value never matches
  // plain always: the declaration initialiser would be a second writer of an always_ff target
  always @(posedge clk_i) begin
    float_q <= ~level_o;
  end
  // device drive wins, then the outside driver, then pull-up or a wandering line
  always_comb begin
    level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i) |
              (~oe_i & ~ext_en_i & (pullup_i | float_q));
  end
endmodule : dppc_pin_env

//--- verif/dppc_top_sva.sv
`timescale 1ns/1ps
`include "dppc_consts.svh"
// ----------------------------------------------------------------
// timing relations watched at the top ports
// ----------------------------------------------------------------
module dppc_top_sva #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // internal bus
  input wire logic [2:0] bus_sel_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  // mode and pins
  input wire logic [2:0] memory_expansion_mode_i,
  input wire logic external_access_pin_i,
  input wire logic [WIDTH-1:0] p3_pin_i,
  input wire logic [WIDTH-1:0] p3_pin_oe_o,
  input wire logic [WIDTH-1:0] alt_in_o,
  input wire logic [WIDTH-1:0] p4_pin_i,
  input wire logic [WIDTH-1:0] p4_pin_o,
  input wire logic [WIDTH-1:0] p4_pin_oe_o,
  input wire logic [WIDTH-1:0] p4_pullup_o,
  input wire logic [WIDTH-1:0] muxed_address_data_low_i,
  input wire logic muxed_address_data_low_oe_i,
  input wire logic [WIDTH-1:0] muxed_address_data_low_o,
  input wire logic [7:0] pullup_option_o,
  input wire logic p4_bus_mode_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // access pin low long enough to cross the synchroniser
  sequence ea_low_held;
    !external_access_pin_i [*5];
  endsequence
  // output code held with the access pin high
  sequence out_code_held;
    (external_access_pin_i && memory_expansion_mode_i == `DPPC_MM_OUTPUT) [*6];
  endsequence
  // pin levels steady for four edges
  sequence pins_steady;
    ($stable(p3_pin_i) && $stable(p4_pin_i)) [*4];
  endsequence
  opt_fields_a: assert property ((pullup_option_o & ~`DPPC_PULLUP_MASK) == 8'h00)
    else $error("pull-up option reserved bit set");
  opt_write_a: assert property (bus_wr_i && bus_sel_i == `DPPC_SEL_PULLUP |=>
    pullup_option_o == ($past(bus_wdata_i) & `DPPC_PULLUP_MASK))
    else $error("pull-up option write lost");
  dir_unread_a: assert property (bus_rd_i && bus_sel_i == `DPPC_SEL_P3_DIR |->
    bus_rdata_o == `DPPC_DIR_READ)
    else $error("direction register readable");
  p4_pullup_a: assert property (
    p4_pullup_o == {WIDTH{$past(pullup_option_o[`DPPC_PU_P4_BIT])}})
    else $error("second port pull-ups not from option bit");
  p4_whole_a: assert property (p4_pin_oe_o == '0 || p4_pin_oe_o == '1)
    else $error("second port direction split");
  reset_idle_a: assert property ($fell(sys_rst_i) |-> p3_pin_oe_o == '0 &&
    p4_pin_oe_o == '0 && p4_pullup_o == '0 && pullup_option_o == 8'h00)
    else $error("pins not idle after reset");
  ea_bus_a: assert property (ea_low_held |-> p4_bus_mode_o)
    else $error("bus mode missing with access pin low");
  out_mode_a: assert property (out_code_held |-> !p4_bus_mode_o && p4_pin_oe_o == '1)
    else $error("output mode not applied");
  bus_drive_a: assert property ($past(p4_bus_mode_o) |->
    p4_pin_oe_o == {WIDTH{$past(muxed_address_data_low_oe_i)}} &&
    (!$past(muxed_address_data_low_oe_i) || p4_pin_o == $past(muxed_address_data_low_i)))
    else $error("bus drive does not follow controller");
  sync_in_a: assert property (pins_steady |-> alt_in_o == p3_pin_i &&
    muxed_address_data_low_o == p4_pin_i)
    else $error("pin levels not passed through");
endmodule : dppc_top_sva
bind dppc_top dppc_top_sva #(.WIDTH(WIDTH)) u_sva (
  .ref_clk_i, .sys_rst_i, .bus_sel_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i, .bus_rdata_o,
  .memory_expansion_mode_i, .external_access_pin_i, .p3_pin_i, .p3_pin_oe_o, .alt_in_o,
  .p4_pin_i, .p4_pin_o, .p4_pin_oe_o, .p4_pullup_o, .muxed_address_data_low_i,
  .muxed_address_data_low_oe_i, .muxed_address_data_low_o, .pullup_option_o, .p4_bus_mode_o);

//--- verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  // ----------------------------------------------------------------
  // stimulus, design outputs and model state
  // ----------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] bus_sel_i = 3'h0;
  logic bus_wr_i = 1'b0, bus_rd_i = 1'b0, bus_bitop_i = 1'b0, ea = 1'b1, ad_oe_i = 1'b0;
  logic [7:0] bus_wdata_i = 8'h00, bus_rdata_o, ext3 = 8'h00, ext4 = 8'h00, ad_i = 8'h00;
  logic [2:0] mm = 3'h0;
  logic [7:0] alt_out_i = 8'h00, alt_oe_i = 8'h00, p3_pin_i, p3_pin_o, p3_pin_oe_o;
  logic [7:0] p3_pullup_o, alt_in_o, p4_pin_i, p4_pin_o, p4_pin_oe_o, p4_pullup_o;
  logic [7:0] ad_o, pullup_option_o;
  logic p4_bus_mode_o;
  logic [7:0] lat3, dir3, fs3, opt, lat4; // model registers
  logic [31:0] seed = 32'd9412; // xorshift state
  int fail_count = 0, tests_run = 0;
  // ----------------------------------------------------------------
  // design and board
  // ----------------------------------------------------------------
  dppc_top u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus_sel_i(bus_sel_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_bitop_i(bus_bitop_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .memory_expansion_mode_i(mm),
    .external_access_pin_i(ea), .p3_pin_i(p3_pin_i), .p3_pin_o(p3_pin_o),
    .p3_pin_oe_o(p3_pin_oe_o), .p3_pullup_o(p3_pullup_o), .alt_out_i(alt_out_i),
    .alt_oe_i(alt_oe_i), .alt_in_o(alt_in_o), .p4_pin_i(p4_pin_i), .p4_pin_o(p4_pin_o),
    .p4_pin_oe_o(p4_pin_oe_o), .p4_pullup_o(p4_pullup_o), .muxed_address_data_low_i(ad_i),
    .muxed_address_data_low_oe_i(ad_oe_i), .muxed_address_data_low_o(ad_o),
    .pullup_option_o(pullup_option_o), .p4_bus_mode_o(p4_bus_mode_o));
  dppc_pin_env u_env3 (.clk_i(ref_clk_i), .oe_i(p3_pin_oe_o), .drv_i(p3_pin_o),
    .pullup_i(p3_pullup_o), .ext_en_i(8'hff), .ext_i(ext3), .level_o(p3_pin_i));
  dppc_pin_env u_env4 (.clk_i(ref_clk_i), .oe_i(p4_pin_oe_o), .drv_i(p4_pin_o),
    .pullup_i(p4_pullup_o), .ext_en_i(8'hff), .ext_i(ext4), .level_o(p4_pin_i));
  // free-running 125 MHz clock
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // access pin low or code 111 hands the second port to the bus
  function automatic logic bus4();
    return !ea || mm == 3'h7;
  endfunction : bus4
  // latches are undefined after reset; the design clears them, so the model does too
  task automatic model_reset();
    lat3 = 8'h00;
    dir3 = 8'hff;
    fs3 = 8'h00;
    opt = 8'h00;
    lat4 = 8'h00;
  endtask : model_reset
  // one write cycle; strobe is left high for a back-to-back follower
  task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic b);
    @(posedge ref_clk_i);
    #1;
    bus_wr_i = 1'b1;
    bus_sel_i = s;
    bus_wdata_i = d;
    bus_bitop_i = b;
    case (s)
      3'h0: lat3 = d;
      3'h1: if (!b) dir3 = d;
      3'h2: fs3 = d;
      // port writes refused in bus mode
      3'h3: if (!bus4()) lat4 = d;
      3'h4: opt = d & 8'h7c;
      default: ;
    endcase
  endtask : wr
  // read data is combinational, taken mid-cycle
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    bus_rd_i = 1'b1;
    bus_sel_i = s;
    #3;
    d = bus_rdata_o;
  endtask : rd
  task automatic idle();
    @(posedge ref_clk_i);
    #1;
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b0;
    bus_bitop_i = 1'b0;
  endtask : idle
  // compare every output and every register read with the model
  task automatic check_all();
    logic [7:0] oe3, po3, lv3, oe4, lv4, r;
    logic [7:0] e [8];
    oe3 = (fs3 & alt_oe_i & 8'hfe) | (~fs3 & ~dir3);
    po3 = (fs3 & alt_out_i) | (~fs3 & lat3);
    lv3 = (oe3 & po3) | (~oe3 & ext3);
    oe4 = (ea && mm == 3'h1) ? 8'hff : (bus4() ? {8{ad_oe_i}} : 8'h00);
    lv4 = (oe4 & (bus4() ? ad_i : lat4)) | (~oe4 & ext4);
    `CHK(p3_pin_oe_o, oe3)
    `CHK(p3_pin_o & oe3, po3 & oe3)
    `CHK(p3_pullup_o, dir3 & (fs3 | {8{opt[3]}}))
    `CHK(alt_in_o, lv3)
    `CHK(p4_bus_mode_o, bus4())
    `CHK(p4_pin_oe_o, oe4)
    `CHK(p4_pin_o & oe4, lv4 & oe4)
    `CHK(ad_o, lv4)
    `CHK(p4_pullup_o, {8{opt[4]}})
    `CHK(pullup_option_o, opt)
    // first port read per pin mode
    e[0] = (dir3 & lv3) | (~dir3 & fs3 & alt_out_i & 8'hfe) | (~dir3 & ~fs3 & lat3);
    e[1] = 8'h00;
    e[2] = fs3;
    e[3] = (ea && mm == 3'h1) ? lat4 : lv4;
    e[4] = opt;
    e[5] = 8'h00;
    e[6] = 8'h00;
    e[7] = 8'h00;
    for (int s = 0; s < 8; s++) begin
      rd(3'(s), r);
      `CHK(r, e[s])
    end
    idle();
  endtask : check_all
  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // main sequence: reset, random traffic, reset again in mid-run
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, q;
    model_reset();
    repeat (10) @(posedge ref_clk_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    check_all();
    for (int i = 0; i < 200; i++) begin
      r = xs();
      q = xs();
      @(posedge ref_clk_i);
      #1;
      ext3 = r[7:0];
      ext4 = r[15:8];
      ea = (r[31:29] != 3'h0);
      // every documented code plus stray ones
      case (r[21:20])
        2'h0: mm = 3'h0;
        2'h1: mm = 3'h1;
        2'h2: mm = 3'h7;
        default: mm = r[24:22];
      endcase
      alt_out_i = q[7:0];
      alt_oe_i = q[15:8];
      ad_i = q[23:16];
      ad_oe_i = q[24];
      repeat (6) @(posedge ref_clk_i);
      // one or two writes back to back, unmapped selects included
      for (int w = 0; w <= int'(q[25]); w++) begin
        r = xs();
        wr(r[2:0], r[15:8], r[16] & r[17]);
      end
      idle();
      repeat (6) @(posedge ref_clk_i);
      check_all();
      if (i == 100) begin
        @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        model_reset();
        repeat (6) @(posedge ref_clk_i);
        check_all();
      end
    end
    results();
  end
endmodule : tb_top
